// ---- src/stre_params.svh ----
// Purpose: Constants for the skip and table read execution unit
// Assumes: One instruction cycle per clock
// Notes: Opcode encodings are local to this unit
`ifndef STRE_PARAMS_SVH
`define STRE_PARAMS_SVH
`define STRE_OP_NONE 3'h0
`define STRE_OP_SZ 3'h1
`define STRE_OP_SZA 3'h2
`define STRE_OP_SZB 3'h3
`define STRE_OP_TRS 3'h4
`define STRE_OP_TRL 3'h5
`define STRE_SKIP_CYCLES 2'h3
`define STRE_TABLE_HIGH_RST 8'h00
`define STRE_ACC_RST 8'h00
`endif

// ---- src/stre_pkg.sv ----
// Purpose: Types for the skip and table read execution unit
// Assumes: Constants come from stre_params.svh
// Notes: None
package stre_pkg;
    typedef enum logic [1:0] {
        STRE_IDLE = 2'h0,
        STRE_FETCH = 2'h1,
        STRE_EXEC = 2'h3,
        STRE_DUMMY = 2'h2
    } stre_state_t;

    typedef struct packed {
        logic [2:0] op;
        logic [2:0] bit_idx;
        logic [7:0] addr;
    } stre_instr_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } stre_dm_wr_t;
endpackage

// ---- src/stre_rdreg.sv ----
// Purpose: Registered read port toward program and data memory
// Assumes: Read data valid one cycle after the request
// Notes: Holds fetched word for the execution cycle
module stre_rdreg #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);
    initial begin
        if (WIDTH < 1) $error("WIDTH must be positive");
    end

    // Capture data word
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_o <= '0;
        end else begin
            data_o <= data_i;
        end
    end
endmodule

// ---- src/stre_exec.sv ----
// Purpose: Executes conditional skips and table reads for the core
// Assumes: Memory read data arrive one clock after the address
// Notes: A taken skip lasts three instruction cycles
`include "stre_params.svh"

// Summary of operation
// - Zero-byte skip rewrites read byte unchanged
// - Zero byte discards the following instruction
// - Taken skip inserts dummy; three cycles total
// - Nonzero value: no dummy, continue normally
// - Copy-skip loads byte into accumulator always
// - Copy-skip skips exactly when byte zero
// - Bit skip tests selected bit, skips zero
// - Specific page read uses both pointers
// - Last page read uses low pointer only
module stre_exec #(
    parameter int PAGE_BITS = 8
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire stre_pkg::stre_instr_t instr_i,
    input wire logic [7:0] table_pointer_low_i,
    input wire logic [PAGE_BITS-1:0] table_pointer_high_i,
    input wire logic [7:0] dm_rdata_i,
    input wire logic [15:0] pm_rdata_i,
    output logic busy_o,
    output logic done_o,
    output logic discard_next_o,
    output logic dummy_o,
    output logic [7:0] dm_raddr_o,
    output logic [PAGE_BITS+7:0] pm_addr_o,
    output stre_pkg::stre_dm_wr_t dm_wr_o,
    output logic acc_we_o,
    output logic [7:0] acc_o,
    output logic [7:0] table_high_byte_latch_o,
    output logic flags_we_o,
    output logic tbp_we_o
);
    initial begin
        if (PAGE_BITS < 1 || PAGE_BITS > 8) $error("PAGE_BITS must be 1..8");
    end

    stre_pkg::stre_state_t state;
    stre_pkg::stre_state_t next_state;
    stre_pkg::stre_instr_t cur;
    logic [7:0] dm_q;
    logic [15:0] pm_q;

    // Registered memory read data
    stre_rdreg #(.WIDTH(8)) u_dm_rd (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .data_i(dm_rdata_i),
        .data_o(dm_q)
    );
    stre_rdreg #(.WIDTH(16)) u_pm_rd (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .data_i(pm_rdata_i),
        .data_o(pm_q)
    );

    // Skip test for a given opcode
    function automatic logic skip_test(input logic [2:0] op, input logic [2:0] idx,
                                       input logic [7:0] v);
        logic r;
        r = 1'b0;
        case (op)
            `STRE_OP_SZ: r = (v == 8'h00);
            `STRE_OP_SZA: r = (v == 8'h00);
            `STRE_OP_SZB: r = ~v[idx];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Opcode match, shared by the decode wires
    function automatic logic op_is(input logic [2:0] op, input logic [2:0] code);
        return op == code;
    endfunction

    // Decode of the incoming instruction; taken only when idle
    wire logic start_ok = start_i && !op_is(instr_i.op, `STRE_OP_NONE);
    wire logic take = (state == stre_pkg::STRE_IDLE) && start_ok;
    wire logic last_page = op_is(instr_i.op, `STRE_OP_TRL);
    wire logic [PAGE_BITS-1:0] page_sel = last_page ?
        {PAGE_BITS{1'b1}} : table_pointer_high_i;

    // Decode of the instruction in execution
    wire logic is_zero_skip = op_is(cur.op, `STRE_OP_SZ);
    wire logic is_copy_skip = op_is(cur.op, `STRE_OP_SZA);
    wire logic is_table = op_is(cur.op, `STRE_OP_TRS) || op_is(cur.op, `STRE_OP_TRL);
    wire logic do_skip = skip_test(cur.op, cur.bit_idx, dm_q);
    wire logic in_exec = (state == stre_pkg::STRE_EXEC);
    wire logic in_dummy = (state == stre_pkg::STRE_DUMMY);
    wire logic skip_now = in_exec && do_skip;
    wire logic wr_back = in_exec && (is_zero_skip || is_table);
    wire logic acc_load = in_exec && is_copy_skip;
    wire logic high_load = in_exec && is_table;
    wire logic [7:0] wr_data = is_table ? pm_q[7:0] : dm_q;
    wire logic finish = (in_exec && !do_skip) || in_dummy;

    // Next state; fetch waits for the registered memory data
    always_comb begin
        next_state = state;
        case (state)
            stre_pkg::STRE_IDLE: begin
                if (start_ok) next_state = stre_pkg::STRE_FETCH;
            end
            stre_pkg::STRE_FETCH: next_state = stre_pkg::STRE_EXEC;
            stre_pkg::STRE_EXEC: begin
                if (do_skip) begin
                    next_state = stre_pkg::STRE_DUMMY;
                end else begin
                    next_state = stre_pkg::STRE_IDLE;
                end
            end
            stre_pkg::STRE_DUMMY: next_state = stre_pkg::STRE_IDLE;
            default: next_state = stre_pkg::STRE_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= stre_pkg::STRE_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Instruction latch; starts while busy are ignored
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur <= '0;
        end else if (take) begin
            cur <= instr_i;
        end
    end

    // Read addresses issued when taken; pointers only read
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dm_raddr_o <= 8'h00;
            pm_addr_o <= '0;
        end else if (take) begin
            dm_raddr_o <= instr_i.addr;
            pm_addr_o <= {page_sel, table_pointer_low_i};
        end
    end

    // Data memory write: byte written back or table low byte
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dm_wr_o <= '0;
        end else begin
            dm_wr_o.we <= wr_back;
            dm_wr_o.addr <= cur.addr;
            dm_wr_o.data <= wr_data;
        end
    end

    // Accumulator write strobe
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_we_o <= 1'b0;
        end else begin
            acc_we_o <= acc_load;
        end
    end

    // Accumulator copy, loaded whether or not the skip follows
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_o <= `STRE_ACC_RST;
        end else if (acc_load) begin
            acc_o <= dm_q;
        end
    end

    // Table high byte latch
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            table_high_byte_latch_o <= `STRE_TABLE_HIGH_RST;
        end else if (high_load) begin
            table_high_byte_latch_o <= pm_q[15:8];
        end
    end

    // Discard request for the following instruction
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            discard_next_o <= 1'b0;
        end else begin
            discard_next_o <= skip_now;
        end
    end

    // Completion pulse, after the dummy cycle when skipping
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= finish;
        end
    end

    // Busy and dummy cycle levels
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_o <= 1'b0;
            dummy_o <= 1'b0;
        end else begin
            busy_o <= (next_state != stre_pkg::STRE_IDLE);
            dummy_o <= (next_state == stre_pkg::STRE_DUMMY);
        end
    end

    // Flag and pointer write strobes, never raised here
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_we_o <= 1'b0;
            tbp_we_o <= 1'b0;
        end else begin
            flags_we_o <= 1'b0;
            tbp_we_o <= 1'b0;
        end
    end
endmodule

// ---- dv/stre_asserts.sv ----
// Purpose: Port checks for the skip and table read unit
// Assumes: Results of one instruction land on one edge
// Notes: Bound to every stre_exec
`include "stre_params.svh"
module stre_asserts #(
    parameter int PAGE_BITS = 8
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire stre_pkg::stre_instr_t instr_i,
    input wire logic [7:0] table_pointer_low_i,
    input wire logic [PAGE_BITS-1:0] table_pointer_high_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic discard_next_o,
    input wire logic dummy_o,
    input wire logic [PAGE_BITS+7:0] pm_addr_o,
    input wire stre_pkg::stre_dm_wr_t dm_wr_o,
    input wire logic acc_we_o,
    input wire logic [7:0] acc_o,
    input wire logic flags_we_o,
    input wire logic tbp_we_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // Dummy cycle then completion
    sequence dummy_s;
        dummy_o ##1 (done_o && !dummy_o);
    endsequence
    // Table read taken on the previous edge
    sequence took_s(logic [2:0] op);
        $rose(busy_o) && $past(start_i && instr_i.op == op);
    endsequence
    flags_hold_a: assert property (!flags_we_o && !tbp_we_o)
        else $error("flag or pointer write");
    skip_len_a: assert property (discard_next_o |-> dummy_s)
        else $error("skip without dummy cycle");
    no_dummy_a: assert property ((dm_wr_o.we || acc_we_o) && !discard_next_o |->
        done_o && !dummy_o)
        else $error("dummy cycle without skip");
    copy_zero_a: assert property (acc_we_o |-> discard_next_o == (acc_o == 8'h00))
        else $error("copy skip mismatch");
    zero_wb_a: assert property (dm_wr_o.we && discard_next_o |->
        dm_wr_o.data == 8'h00)
        else $error("skip on nonzero byte");
    spec_page_a: assert property (took_s(`STRE_OP_TRS) |->
        pm_addr_o == {$past(table_pointer_high_i), $past(table_pointer_low_i)})
        else $error("table address wrong");
    last_page_a: assert property (took_s(`STRE_OP_TRL) |->
        pm_addr_o == {{PAGE_BITS{1'b1}}, $past(table_pointer_low_i)})
        else $error("last page address wrong");
    len_bound_a: assert property ($rose(busy_o) |-> busy_o ##[2:3] done_o)
        else $error("instruction length wrong");
endmodule
bind stre_exec stre_asserts #(.PAGE_BITS(PAGE_BITS)) u_chk (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .start_i(start_i),
    .instr_i(instr_i),
    .table_pointer_low_i(table_pointer_low_i),
    .table_pointer_high_i(table_pointer_high_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .discard_next_o(discard_next_o),
    .dummy_o(dummy_o),
    .pm_addr_o(pm_addr_o),
    .dm_wr_o(dm_wr_o),
    .acc_we_o(acc_we_o),
    .acc_o(acc_o),
    .flags_we_o(flags_we_o),
    .tbp_we_o(tbp_we_o)
);

// ---- dv/stre_exec_tb.sv ----
// Purpose: Self-checking bench for the skip and table read unit
// Assumes: Memories answer combinationally from the read addresses
// Notes: Expected results queue, checked when done_o pulses
`include "stre_params.svh"
module stre_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic sk; logic [7:0] wd; logic [7:0] wa; logic [7:0] lat;} stre_note_t;
    logic clk_sys_i = 0, arst_n_i = 0, start_i = 0;
    stre_pkg::stre_instr_t instr_i = '0;
    logic [7:0] tpl = 0, tph = 0, dm [256], dm_raddr_o, acc_o, lat_o;
    logic busy_o, done_o, disc_o, dummy_o, acc_we_o;
    logic [15:0] pm_addr_o;
    stre_pkg::stre_dm_wr_t dm_wr_o;
    stre_note_t q[$], got = '0, e = '0;
    int errors = 0, total_checks = 0;
    // Clock
    always #12.5 clk_sys_i = ~clk_sys_i;
    stre_exec u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .start_i(start_i),
        .instr_i(instr_i), .table_pointer_low_i(tpl), .table_pointer_high_i(tph),
        .dm_rdata_i(dm[dm_raddr_o]), .pm_rdata_i(pm_addr_o ^ 16'hA55A), .busy_o(busy_o),
        .done_o(done_o), .discard_next_o(disc_o), .dummy_o(dummy_o), .dm_raddr_o(dm_raddr_o),
        .pm_addr_o(pm_addr_o), .dm_wr_o(dm_wr_o), .acc_we_o(acc_we_o), .acc_o(acc_o),
        .table_high_byte_latch_o(lat_o), .flags_we_o(), .tbp_we_o());
    task fail(input string m);
        $display("unexpected at %0t: %s", $time, m);
        errors++;
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Result watcher
    always @(posedge clk_sys_i) begin
        #1;
        if (dm_wr_o.we === 1'b1) got.wd = dm_wr_o.data;
        if (dm_wr_o.we === 1'b1 && dm_wr_o.addr !== instr_i.addr) fail("write address");
        if (acc_we_o === 1'b1) got.wa = acc_o;
        if (disc_o === 1'b1) got.sk = 1'b1;
        if (done_o === 1'b1) begin
            got.lat = lat_o;
            total_checks++;
            if (q.size() == 0) fail("result without note");
            else if (got !== q.pop_front()) fail("result");
            got.sk = 1'b0;
        end
    end
    // One instruction with its expected outcome; hold keeps start high one more cycle, through the fetch cycle
    task run(input logic [2:0] op, input logic [7:0] v, input bit hold);
        int n;
        logic [15:0] w;
        instr_i = {op, 3'($urandom), 8'($urandom)};
        tpl = 8'($urandom);
        tph = 8'($urandom);
        dm[instr_i.addr] = v;
        w = ((op == `STRE_OP_TRL) ? {8'hFF, tpl} : {tph, tpl}) ^ 16'hA55A;
        e.sk = (op < `STRE_OP_SZB) && (v == 8'h00);
        if (op == `STRE_OP_SZB) e.sk = !v[instr_i.bit_idx];
        if (op == `STRE_OP_SZ) e.wd = v;
        if (op >= `STRE_OP_TRS) e.wd = w[7:0];
        if (op == `STRE_OP_SZA) e.wa = v;
        if (op >= `STRE_OP_TRS) e.lat = w[15:8];
        q.push_back(e);
        start_i = 1;
        @(negedge clk_sys_i) start_i = hold;
        @(negedge clk_sys_i) start_i = 0;
        for (n = 0; n < 10 && done_o !== 1'b1; n++) @(negedge clk_sys_i);
        if (n == 10) begin
            fail("no completion");
            give_verdict();
        end
    endtask
    // Opcode zero is refused: no busy level and no result
    task run_none;
        instr_i = {`STRE_OP_NONE, 3'($urandom), 8'($urandom)};
        start_i = 1;
        @(negedge clk_sys_i) start_i = 0;
        total_checks++;
        if (busy_o !== 1'b0) fail("busy after refused start");
        repeat (3) @(negedge clk_sys_i);
    endtask
    // Reset, then every operation with zero and nonzero data
    initial begin
        void'($urandom(30771));
        repeat (10) @(negedge clk_sys_i);
        arst_n_i = 1;
        @(negedge clk_sys_i);
        for (int i = 0; i < 40; i++) begin
            run(3'(1 + i % 5), (i % 10 < 5) ? 8'h00 : 8'($urandom),
                i % 7 == 0);
            $display("test %0d done", i);
        end
        run_none();
        $display("test refused opcode done");
        repeat (3) @(negedge clk_sys_i);
        give_verdict();
    end
endmodule
